// ### afecs_clock_ctrl.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Summary of operation
// - wake timer clock comes from slow oscillator
// - fast oscillator offers 16 or 32 MHz
// - converter clock path is never divided
// - power-up selects fast oscillator at 16 MHz
// - system clock equals root over divide value
// - divide values above 32 act as 32
// - divide zero behaves as divide one
// - converter source field bits 3:2 encoding
// - system source field bits 1:0, reset 00
// - bit 2 stops chop clock, resets stopped
// - bit 1 stops wake timer clock, resets running
// - key register write-only, resets to zero
module afecs_clock_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic [afecs_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [afecs_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [afecs_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic fast_internal_oscillator,
    input wire logic crystal_clock,
    input wire logic slow_internal_oscillator,
    input wire logic external_clock_input_pin,
    input wire logic amp_chop_source,
    output logic system_clock,
    output logic converter_clock,
    output logic amp_chop_clock,
    output logic wake_timer_clock,
    output logic fast_osc_32m_select
);
    import afecs_pkg::*;

    // register state
    logic [15:0] system_clock_divider_config_r;
    logic [15:0] clock_gate_enable_main_r;
    logic [3:0] clock_source_select_r;
    logic [2:0] chop_and_wake_timer_clock_gate_r;
    logic [31:0] fast_oscillator_config_r;
    logic divider_unlocked_r;

    // bus slave state
    afecs_bus_t bus_st_r;
    logic [DATA_W-1:0] readdata_r;
    logic waitreq_r;
    logic [1:0] resp_r;
    logic [DATA_W-1:0] rd_nxt;
    logic hit_nxt;
    logic wr_acc;
    logic [DATA_W-1:0] bmask;
    logic [15:0] wr16;

    // synchronised source levels
    logic [4:0] pin_lvl;
    logic [3:0] src_lvl;
    logic chop_lvl;

    // gates and effective divide
    logic [5:0] system_clock_divide_field;
    logic [5:0] div_eff;
    logic chop_gate_r;
    logic wake_gate_r;
    logic amp_chop_clock_r;
    logic wake_timer_clock_r;

    afecs_path_if sys_if ();
    afecs_path_if adc_if ();

    // every source is asynchronous to clk, so all share one sync bank
    afecs_pin_sync #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .pin({amp_chop_source, external_clock_input_pin, slow_internal_oscillator,
              crystal_clock, fast_internal_oscillator}),
        .lvl(pin_lvl)
    );

    assign src_lvl = pin_lvl[3:0];
    assign chop_lvl = pin_lvl[4];

    // divide field saturates at 32 and treats zero as one
    assign system_clock_divide_field = system_clock_divider_config_r[DIV_LSB +: DIV_W];
    always_comb begin
        if (system_clock_divide_field == 6'h00) begin
            div_eff = DIV_MIN;
        end else if (system_clock_divide_field > DIV_MAX) begin
            div_eff = DIV_MAX;
        end else begin
            div_eff = system_clock_divide_field;
        end
    end

    // system clock path: selectable source with the divider
    assign sys_if.src_lvl = src_lvl;
    assign sys_if.sel = afecs_src_t'(clock_source_select_r[SYS_SEL_LSB +: 2]);
    assign sys_if.div = div_eff;

    // converter clock path: its own source field, divide pinned to one
    assign adc_if.src_lvl = src_lvl;
    assign adc_if.sel = afecs_src_t'(clock_source_select_r[ADC_SEL_LSB +: 2]);
    assign adc_if.div = DIV_MIN;

    afecs_clk_path u_sys_path (
        .clk(clk),
        .srst(srst),
        .pif(sys_if)
    );

    afecs_clk_path u_adc_path (
        .clk(clk),
        .srst(srst),
        .pif(adc_if)
    );

    // byte lane mask and the low halfword of write data with disabled lanes cleared
    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr16 = avs_writedata[15:0] & bmask[15:0];

    // a write takes effect only on the edge where waitrequest is seen low
    assign wr_acc = (bus_st_r == BUS_ANSWER) && avs_write;

    // read mux and decode; key and foreign registers read as zero
    always_comb begin
        rd_nxt = '0;
        hit_nxt = 1'b1;
        if (avs_address == OFS_DIVCFG) begin
            rd_nxt[15:0] = system_clock_divider_config_r;
        end else if (avs_address == OFS_CLOCK_GATE_ENABLE_MAIN) begin
            rd_nxt[15:0] = clock_gate_enable_main_r;
        end else if (avs_address == OFS_CLOCK_SOURCE_SELECT) begin
            rd_nxt[3:0] = clock_source_select_r;
        end else if (avs_address == OFS_DIVKEY) begin
            rd_nxt = '0;
        end else if (avs_address == OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE) begin
            rd_nxt[2:0] = chop_and_wake_timer_clock_gate_r;
        end else if (avs_address == OFS_HSOSC) begin
            rd_nxt = fast_oscillator_config_r;
        end else if (avs_address == OFS_STATUS) begin
            rd_nxt[1:0] = sys_if.active_sel;
            rd_nxt[3:2] = adc_if.active_sel;
            rd_nxt[9:4] = sys_if.active_div;
            rd_nxt[10] = divider_unlocked_r;
            rd_nxt[11] = system_clock;
        end else if (avs_address == OFS_OSCILLATOR_UNLOCK_KEY || avs_address == OFS_OSCILLATOR_CONTROL ||
                     avs_address == OFS_RSTKEY || avs_address == OFS_SLOW_OSCILLATOR_TEST) begin
            rd_nxt = '0; // owned by the oscillator block, mapped but inert here
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // one wait cycle per access keeps the read mux off the output path
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_st_r <= BUS_IDLE;
            waitreq_r <= 1'b1;
            readdata_r <= '0;
            resp_r <= RESP_OK;
        end else begin
            case (bus_st_r)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_st_r <= BUS_ANSWER;
                        waitreq_r <= 1'b0;
                        readdata_r <= avs_read ? rd_nxt : '0;
                        resp_r <= hit_nxt ? RESP_OK : RESP_SLVERR;
                    end
                end
                BUS_ANSWER: begin
                    bus_st_r <= BUS_IDLE;
                    waitreq_r <= 1'b1;
                end
                default: begin
                    bus_st_r <= BUS_IDLE;
                    waitreq_r <= 1'b1;
                end
            endcase
        end
    end

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitreq_r;
    assign avs_response = resp_r;

    // key lock: only a full 16-bit key write opens it, any other
    // accepted write closes it, so a stray write cannot slip through
    always_ff @(posedge clk) begin
        if (srst) begin
            divider_unlocked_r <= 1'b0;
        end else if (wr_acc) begin
            if (avs_address == OFS_DIVKEY) begin
                divider_unlocked_r <= (avs_byteenable[1:0] == 2'b11) &&
                                      (avs_writedata[15:0] == KEY_UNLOCK);
            end else begin
                divider_unlocked_r <= 1'b0;
            end
        end
    end

    // divider config: the reserved upper bits are stored as written,
    // keeping their pattern is left to software
    always_ff @(posedge clk) begin
        if (srst) begin
            system_clock_divider_config_r <= RST_DIVCFG;
        end else if (wr_acc && avs_address == OFS_DIVCFG && divider_unlocked_r) begin
            system_clock_divider_config_r <= (system_clock_divider_config_r & ~bmask[15:0])
                                             | wr16;
        end
    end

    // source select, both fields reset to the fast oscillator
    always_ff @(posedge clk) begin
        if (srst) begin
            clock_source_select_r <= RST_CLOCK_SOURCE_SELECT;
        end else if (wr_acc && avs_address == OFS_CLOCK_SOURCE_SELECT && avs_byteenable[0]) begin
            clock_source_select_r <= avs_writedata[3:0];
        end
    end

    // main clock gate register, plain storage for the wider system
    always_ff @(posedge clk) begin
        if (srst) begin
            clock_gate_enable_main_r <= RST_CLOCK_GATE_ENABLE_MAIN;
        end else if (wr_acc && avs_address == OFS_CLOCK_GATE_ENABLE_MAIN) begin
            clock_gate_enable_main_r <= (clock_gate_enable_main_r & ~bmask[15:0]) | wr16;
        end
    end

    // chop and wake timer gate bits
    always_ff @(posedge clk) begin
        if (srst) begin
            chop_and_wake_timer_clock_gate_r <= RST_CHOP_AND_WAKE_TIMER_CLOCK_GATE;
        end else if (wr_acc && avs_address == OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE && avs_byteenable[0]) begin
            chop_and_wake_timer_clock_gate_r <= avs_writedata[2:0];
        end
    end

    // fast oscillator config, one bit picks the 32 MHz setting
    always_ff @(posedge clk) begin
        if (srst) begin
            fast_oscillator_config_r <= RST_HSOSC;
        end else if (wr_acc && avs_address == OFS_HSOSC) begin
            fast_oscillator_config_r <= (fast_oscillator_config_r & ~bmask) |
                                        (avs_writedata & bmask);
        end
    end

    assign fast_osc_32m_select = fast_oscillator_config_r[HS32_BIT];

    // gate enables move only while their source is low, so a gate
    // change can never cut a high phase short
    always_ff @(posedge clk) begin
        if (srst) begin
            chop_gate_r <= 1'b0;
            wake_gate_r <= 1'b0;
        end else begin
            if (!chop_lvl) begin
                chop_gate_r <= ~chop_and_wake_timer_clock_gate_r[CHOP_OFF_BIT];
            end
            if (!src_lvl[SRC_SLOW]) begin
                wake_gate_r <= ~chop_and_wake_timer_clock_gate_r[WAKE_OFF_BIT];
            end
        end
    end

    // gated outputs, registered so the top drives only flops
    always_ff @(posedge clk) begin
        if (srst) begin
            amp_chop_clock_r <= 1'b0;
            wake_timer_clock_r <= 1'b0;
        end else begin
            amp_chop_clock_r <= chop_lvl & chop_gate_r;
            wake_timer_clock_r <= src_lvl[SRC_SLOW] & wake_gate_r;
        end
    end

    assign amp_chop_clock = amp_chop_clock_r;
    assign wake_timer_clock = wake_timer_clock_r;
    assign system_clock = sys_if.clk_lvl;
    assign converter_clock = adc_if.clk_lvl;
endmodule // afecs_clock_ctrl

// ### afecs_pkg.sv
package afecs_pkg;
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [15:0] OFS_DIVCFG = 16'h0408;
    localparam logic [15:0] OFS_CLOCK_GATE_ENABLE_MAIN = 16'h0410;
    localparam logic [15:0] OFS_CLOCK_SOURCE_SELECT = 16'h0414;
    localparam logic [15:0] OFS_DIVKEY = 16'h0420;
    localparam logic [15:0] OFS_STATUS = 16'h0440;
    localparam logic [15:0] OFS_OSCILLATOR_UNLOCK_KEY = 16'h0a0c;
    localparam logic [15:0] OFS_OSCILLATOR_CONTROL = 16'h0a10;
    localparam logic [15:0] OFS_RSTKEY = 16'h0a5c;
    localparam logic [15:0] OFS_SLOW_OSCILLATOR_TEST = 16'h0a6c;
    localparam logic [15:0] OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE = 16'h0a70;
    localparam logic [15:0] OFS_HSOSC = 16'h20bc;

    // values after reset
    localparam logic [15:0] RST_DIVCFG = 16'h0441;
    localparam logic [15:0] RST_CLOCK_GATE_ENABLE_MAIN = 16'h01c0;
    localparam logic [3:0] RST_CLOCK_SOURCE_SELECT = 4'h0;
    localparam logic [2:0] RST_CHOP_AND_WAKE_TIMER_CLOCK_GATE = 3'h4;
    localparam logic [31:0] RST_HSOSC = 32'h0000_0034;

    // unlock value of the divider key
    localparam logic [15:0] KEY_UNLOCK = 16'ha815;

    // field positions
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 6;
    localparam int SYS_SEL_LSB = 0;
    localparam int ADC_SEL_LSB = 2;
    localparam int WAKE_OFF_BIT = 1;
    localparam int CHOP_OFF_BIT = 2;
    localparam int HS32_BIT = 3;
    localparam logic [5:0] DIV_MIN = 6'h01;
    localparam logic [5:0] DIV_MAX = 6'h20;

    // avalon response codes
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // clock source encoding shared by both select fields
    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_SLOW = 2'b10,
        SRC_EXT = 2'b11
    } afecs_src_t;

    // register slave states
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } afecs_bus_t;
endpackage

// ### afecs_path_if.sv
`timescale 1ns/1ps
interface afecs_path_if;
    import afecs_pkg::*;
    logic [3:0] src_lvl;
    afecs_src_t sel;
    logic [5:0] div;
    logic clk_lvl;
    afecs_src_t active_sel;
    logic [5:0] active_div;
    modport ctrl(output src_lvl, sel, div, input clk_lvl, active_sel, active_div);
    modport path(input src_lvl, sel, div, output clk_lvl, active_sel, active_div);
endinterface

// ### afecs_pin_sync.sv
`timescale 1ns/1ps
module afecs_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // three stage chain, first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            lvl <= '0;
        end else begin
            lvl <= (s2_r & s3_r) | (lvl & (s2_r ^ s3_r));
        end
    end
endmodule // afecs_pin_sync

// ### afecs_clk_path.sv
`timescale 1ns/1ps
module afecs_clk_path (
    input wire logic clk,
    input wire logic srst,
    afecs_path_if.path pif
);
    import afecs_pkg::*;
    afecs_src_t sel_r;
    logic [5:0] div_r;
    logic [6:0] cnt_r;
    logic prev_r;
    logic out_r;
    logic wait_r;
    logic cur;
    logic rise;
    logic edg;
    logic wrap;
    logic pend;
    logic [6:0] cnt_inc;
    logic [6:0] period;

    // edges of the selected source, period counted in half cycles
    assign cur = pif.src_lvl[sel_r];
    assign rise = cur & ~prev_r;
    assign edg = cur ^ prev_r;
    assign period = {div_r, 1'b0};
    assign cnt_inc = cnt_r + 7'h01;
    assign wrap = edg & (cnt_inc == period);
    assign pend = (pif.sel != sel_r) | (pif.div != div_r);

    // changes land only at the end of a low phase, then the output
    // stays low until the new source rises: no runt pulse either way
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_r <= SRC_FAST;
            div_r <= DIV_MIN;
            cnt_r <= 7'h00;
            prev_r <= 1'b0;
            out_r <= 1'b0;
            wait_r <= 1'b1;
        end else if (wait_r) begin
            prev_r <= cur;
            if (rise) begin
                wait_r <= 1'b0;
                out_r <= 1'b1;
                cnt_r <= 7'h00;
            end
        end else if (wrap && pend) begin
            sel_r <= pif.sel;
            div_r <= pif.div;
            prev_r <= pif.src_lvl[pif.sel];
            wait_r <= 1'b1;
            out_r <= 1'b0;
            cnt_r <= 7'h00;
        end else if (edg) begin
            prev_r <= cur;
            cnt_r <= wrap ? 7'h00 : cnt_inc;
            out_r <= wrap | (cnt_inc < {1'b0, div_r});
        end
    end

    assign pif.clk_lvl = out_r;
    assign pif.active_sel = sel_r;
    assign pif.active_div = div_r;
endmodule // afecs_clk_path

// ### afecs_clock_ctrl_properties.sv
`timescale 1ns/1ps
module afecs_clock_ctrl_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic [afecs_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [afecs_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [afecs_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic slow_internal_oscillator,
    input wire logic system_clock,
    input wire logic converter_clock,
    input wire logic amp_chop_clock,
    input wire logic wake_timer_clock
);
    import afecs_pkg::*;
    logic chop_off_r;
    logic wake_off_r;
    logic slow_q_r;
    logic [3:0] chop_cnt_r;
    logic [3:0] wake_cnt_r;
    logic [3:0] slow_age_r;
    logic gate_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // a gate register write completes at the edge that sees waitrequest low
    assign gate_wr = avs_write && !avs_waitrequest && avs_address == OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE
        && avs_byteenable[0];
    // shadow of the two gate bits, reset stopped chop and running wake timer
    always_ff @(posedge clk) begin
        if (srst) begin
            chop_off_r <= 1'b1;
            wake_off_r <= 1'b0;
        end else if (gate_wr) begin
            chop_off_r <= avs_writedata[CHOP_OFF_BIT];
            wake_off_r <= avs_writedata[WAKE_OFF_BIT];
        end
    end
    // cycles a gate has been off, saturating; 15 leaves room for sync and lag
    always_ff @(posedge clk) begin
        if (srst || !chop_off_r) begin
            chop_cnt_r <= 4'h0;
        end else if (chop_cnt_r != 4'hf) begin
            chop_cnt_r <= chop_cnt_r + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || !wake_off_r) begin
            wake_cnt_r <= 4'h0;
        end else if (wake_cnt_r != 4'hf) begin
            wake_cnt_r <= wake_cnt_r + 4'h1;
        end
    end
    // age of the last rising edge of the slow oscillator
    always_ff @(posedge clk) begin
        slow_q_r <= slow_internal_oscillator;
        if (srst || (slow_internal_oscillator && !slow_q_r)) begin
            slow_age_r <= 4'h0;
        end else if (slow_age_r != 4'hf) begin
            slow_age_r <= slow_age_r + 4'h1;
        end
    end
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stayed low past one cycle");
    answer_next_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered on the next edge");
    key_reads_zero_a: assert property (
        avs_read && !avs_waitrequest && avs_address == OFS_DIVKEY |-> avs_readdata == 32'h0)
        else $error("key register read back nonzero");
    chop_held_off_a: assert property (chop_cnt_r == 4'hf |-> !$rose(amp_chop_clock))
        else $error("chop clock rose while gated off");
    wake_held_off_a: assert property (wake_cnt_r == 4'hf |-> !$rose(wake_timer_clock))
        else $error("wake timer clock rose while gated off");
    wake_from_slow_a: assert property ($rose(wake_timer_clock) |-> slow_age_r <= 4'h8)
        else $error("wake timer edge not tied to slow oscillator");
    sys_no_runt_a: assert property ($changed(system_clock) |=> $stable(system_clock))
        else $error("one-cycle pulse on system clock");
    conv_no_runt_a: assert property (
        $changed(converter_clock) |=> $stable(converter_clock))
        else $error("one-cycle pulse on converter clock");
endmodule // afecs_clock_ctrl_props

bind afecs_clock_ctrl afecs_clock_ctrl_props u_props (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_internal_oscillator(slow_internal_oscillator), .system_clock(system_clock),
    .converter_clock(converter_clock), .amp_chop_clock(amp_chop_clock),
    .wake_timer_clock(wake_timer_clock)
);

// ### afecs_clock_ctrl_tb.sv
`timescale 1ns/1ps
module afecs_clock_ctrl_tb;
    import afecs_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] avs_address = 16'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic [4:0] src_r = 5'h0;
    logic system_clock, converter_clock, amp_chop_clock, wake_timer_clock, fast_osc_32m_select;
    int n_mismatch = 0;
    int n_compared = 0;
    int cnt [5];
    // half periods: fast, crystal, slow, external, chop; all slow enough for the syncs
    int half [5] = '{2, 3, 5, 4, 3};

    afecs_clock_ctrl uut (
        .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .fast_internal_oscillator(src_r[0]), .crystal_clock(src_r[1]),
        .slow_internal_oscillator(src_r[2]), .external_clock_input_pin(src_r[3]),
        .amp_chop_source(src_r[4]), .system_clock(system_clock),
        .converter_clock(converter_clock), .amp_chop_clock(amp_chop_clock),
        .wake_timer_clock(wake_timer_clock), .fast_osc_32m_select(fast_osc_32m_select)
    );

    always #25 clk = ~clk;

    // source oscillators, stepped on the rising edge so the syncs see clean levels
    always @(posedge clk) begin
        for (int k = 0; k < 5; k++) begin
            if (cnt[k] >= half[k] - 1) begin
                cnt[k] <= 0;
                src_r[k] <= ~src_r[k];
            end else begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon access; the request is held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            n_mismatch++;
            tally_and_finish();
        end else begin
            rd = avs_readdata;
            rs = avs_response;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic [1:0] r;
        bus(1'b1, a, d, 4'hf, x, r);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [31:0] x;
        logic [1:0] r;
        bus(1'b0, a, 32'h0, 4'hf, x, r);
        check(x, e);
        check({30'h0, r}, {30'h0, re});
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return system_clock;
            1: return converter_clock;
            2: return amp_chop_clock;
            default: return wake_timer_clock;
        endcase
    endfunction

    // period of an output between two rising edges; the second pair skips a switchover
    task automatic per_chk(input int k, input int exp);
        int n, seen, t0, p;
        logic prev, v;
        seen = 0;
        t0 = 0;
        p = 0;
        prev = 1'b1;
        for (n = 0; n < 1000 && seen < 3; n++) begin
            @(posedge clk);
            v = pick(k);
            if (v === 1'b1 && prev === 1'b0) begin
                seen++;
                p = n - t0;
                t0 = n;
            end
            prev = v;
        end
        if (seen < 3) begin
            n_mismatch++;
            tally_and_finish();
        end else begin
            check(p, exp);
        end
    endtask

    // rising edges of a gated output after it has had time to settle
    task automatic rises_chk(input int k, input int exp);
        int c;
        logic prev;
        c = 0;
        repeat (20) @(posedge clk);
        prev = pick(k);
        repeat (40) begin
            @(posedge clk);
            if (pick(k) === 1'b1 && prev !== 1'b1) c++;
            prev = pick(k);
        end
        check(c, exp);
    endtask

    task automatic t_reset();
        rd_chk(OFS_DIVCFG, 32'h0441, RESP_OK);
        rd_chk(OFS_CLOCK_GATE_ENABLE_MAIN, 32'h01c0, RESP_OK);
        rd_chk(OFS_CLOCK_SOURCE_SELECT, 32'h0, RESP_OK);
        rd_chk(OFS_DIVKEY, 32'h0, RESP_OK);
        rd_chk(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h4, RESP_OK);
        rd_chk(OFS_HSOSC, 32'h34, RESP_OK);
        check(fast_osc_32m_select, 1'b0);
        per_chk(0, 2 * half[0]);
        rises_chk(2, 0);
        per_chk(3, 2 * half[2]);
    endtask

    // every source code on both fields, crossed so a swapped field shows
    task automatic t_sources();
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CLOCK_SOURCE_SELECT, {28'h0, 2'(3 - s), 2'(s)});
            rd_chk(OFS_CLOCK_SOURCE_SELECT, {28'h0, 2'(3 - s), 2'(s)}, RESP_OK);
            per_chk(0, 2 * half[s]);
            per_chk(1, 2 * half[3 - s]);
        end
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h0);
    endtask

    // divide values stored as written, effective value saturated
    task automatic t_divide();
        int dv [5] = '{0, 2, 3, 33, 63};
        int ef [5] = '{1, 2, 3, 32, 32};
        for (int i = 0; i < 5; i++) begin
            wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
            wr(OFS_DIVCFG, 32'h0400 | dv[i]);
            rd_chk(OFS_DIVCFG, 32'h0400 | dv[i], RESP_OK);
            per_chk(0, 2 * half[0] * ef[i]);
        end
        // a 32 MHz crystal or external root is halved by software before use
        wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
        wr(OFS_DIVCFG, 32'h0402);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h1);
        per_chk(0, 4 * half[1]);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h3);
        per_chk(0, 4 * half[3]);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h0);
    endtask

    task automatic t_lock();
        logic [31:0] x;
        logic [1:0] r;
        wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
        wr(OFS_DIVCFG, 32'h0401);
        wr(OFS_DIVCFG, 32'h0403);
        rd_chk(OFS_DIVCFG, 32'h0401, RESP_OK);
        wr(OFS_DIVKEY, 32'ha814);
        wr(OFS_DIVCFG, 32'h0403);
        rd_chk(OFS_DIVCFG, 32'h0401, RESP_OK);
        bus(1'b1, OFS_DIVKEY, {16'h0, KEY_UNLOCK}, 4'h1, x, r);
        wr(OFS_DIVCFG, 32'h0403);
        rd_chk(OFS_DIVCFG, 32'h0401, RESP_OK);
        wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h0);
        wr(OFS_DIVCFG, 32'h0403);
        rd_chk(OFS_DIVCFG, 32'h0401, RESP_OK);
        wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
        wr(OFS_DIVCFG, 32'h0402);
        wr(OFS_DIVCFG, 32'h0403);
        rd_chk(OFS_DIVCFG, 32'h0402, RESP_OK);
        per_chk(0, 4 * half[0]);
        wr(OFS_DIVKEY, {16'h0, KEY_UNLOCK});
        wr(OFS_DIVCFG, 32'h0441);
    endtask

    task automatic t_gates();
        wr(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h0);
        rd_chk(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h0, RESP_OK);
        per_chk(2, 2 * half[4]);
        wr(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h6);
        rises_chk(2, 0);
        rises_chk(3, 0);
        wr(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h2);
        per_chk(2, 2 * half[4]);
        rises_chk(3, 0);
        wr(OFS_CHOP_AND_WAKE_TIMER_CLOCK_GATE, 32'h4);
        per_chk(3, 2 * half[2]);
    endtask

    task automatic t_misc();
        wr(16'h0500, 32'hffff);
        rd_chk(16'h0500, 32'h0, RESP_SLVERR);
        wr(OFS_HSOSC, 32'h3c);
        rd_chk(OFS_HSOSC, 32'h3c, RESP_OK);
        @(posedge clk);
        check(fast_osc_32m_select, 1'b1);
        wr(OFS_HSOSC, 32'h34);
        // the write lands on the edge the task returns at; look one edge later
        @(posedge clk);
        check(fast_osc_32m_select, 1'b0);
        wr(OFS_CLOCK_GATE_ENABLE_MAIN, 32'h01c9);
        rd_chk(OFS_CLOCK_GATE_ENABLE_MAIN, 32'h01c9, RESP_OK);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_sources();
        t_divide();
        t_lock();
        t_gates();
        t_misc();
        tally_and_finish();
    end
endmodule // afecs_clock_ctrl_tb
